/* shared/gdfm_defs.svh */
// Timing counts and reset values for the gate driver fault manager
`ifndef GDFM_DEFS_SVH
`define GDFM_DEFS_SVH
`define GDFM_CLK_NS 100
`define GDFM_HW_DEGLITCH_NS 4000
`define GDFM_HW_DEGLITCH_CYC ((`GDFM_HW_DEGLITCH_NS + `GDFM_CLK_NS - 1) / `GDFM_CLK_NS)
`define GDFM_DEG_W 8
`define GDFM_RETRY_W 16
`define GDFM_DRIVE_W 12
`define GDFM_RST_W 12
`define GDFM_OVERCURRENT_MODE_SEL_RST 2'h0
`define GDFM_THERMAL_SHUTDOWN_RECOVERY_SEL_RST 1'h0
`endif

/* shared/gdfm_pkg.sv */
// Types for the gate driver fault manager
package gdfm_pkg;
	typedef enum logic [1:0] {
		GDFM_OCP_LATCH = 2'b00,
		GDFM_OCP_RETRY = 2'b01,
		GDFM_OCP_REPORT = 2'b10,
		GDFM_OCP_OFF = 2'b11
	} gdfm_overcurrent_mode_sel_t;
	typedef enum logic [2:0] {
		GDFM_PWM_6X = 3'b000,
		GDFM_PWM_3X = 3'b001,
		GDFM_PWM_1X = 3'b010,
		GDFM_IND_HB = 3'b011,
		GDFM_IND_4 = 3'b100,
		GDFM_IND_5 = 3'b101,
		GDFM_IND_6 = 3'b110,
		GDFM_IND_FET = 3'b111
	} gdfm_mode_t;
endpackage : gdfm_pkg

/* rtl/gdfm_fault_manager.sv */
// Fault manager: protection, flags, gate gating and error indicator
// Function
// - Supply UV: gates off, pump off, flags.
// - Supply UV recovers automatically; flag stays latched.
// - Pump UV: gates off, indicator low, flags.
// - Pump UV disable keeps running, still flags.
// - Overcurrent after deglitch; response by mode.
// - Pin variant: 4 us deglitch, latched.
// - Mode 00: latched shutdown until clear.
// - Mode 01: shutdown, auto retry clears flags.
// - Mode 10: report only, gates keep running.
// - Mode 11: monitor off, bridge disables locked.
// - Gate fault when gate misses window.
// - Gate fault: indicator, flags, clear to resume.
// - Gate fault disable: flag only, no stop.
// - PWM modes: gate fault kills all six.
// - Half-bridge mode: fault kills that bridge.
// - FET modes: fault kills only that FET, or its whole bridge if PHASE_IND_HB marks that phase.
// - Thermal warning flag; indicator if reporting.
// - Thermal shutdown: gates, pump off, flags.
// - Latched thermal recovery needs a clear event (command, enable or sleep pulse).
// - Thermal pump off raises no pump flag.
// - Global flag is OR of faults.
// - Auto thermal recovery; flag stays latched.
`include "gdfm_defs.svh"
module gdfm_fault_manager (
	input wire logic CORE_CLK, // 10 MHz clock
	input wire logic RSTN, // Async reset, active low
	input wire logic HW_VARIANT, // Pin-configured variant
	input wire logic SUPPLY_UV, // Supply undervoltage comparator
	input wire logic PUMP_UV, // Charge pump undervoltage comparator
	input wire logic [5:0] DS_OVER, // Drain-source comparators per FET
	input wire logic [5:0] GATE_CMD, // Commanded gate states
	input wire logic [5:0] GATE_SENSE, // Sensed gate voltage reached
	input wire logic THERM_WARN, // Thermal warning comparator
	input wire logic THERM_SD, // Thermal shutdown comparator
	input wire logic ENABLE, // Enable pin
	input wire logic SLEEP_CONTROL_N, // Sleep pin, active low
	input wire logic CLEAR_FAULTS_CMD, // Clear command write strobe
	input wire gdfm_pkg::gdfm_overcurrent_mode_sel_t OVERCURRENT_MODE_SEL, // Overcurrent response
	input wire logic [`GDFM_DEG_W-1:0] OVERCURRENT_DEGLITCH_SEL, // Deglitch cycles
	input wire logic HW_OC_DISABLED, // Threshold pin selects disabled
	input wire logic [2:0] BRIDGE_OVERCURRENT_DISABLE, // Per-bridge monitor off
	input wire logic BRIDGE_DIS_WRITE, // Write strobe for bridge disables
	input wire logic [`GDFM_RETRY_W-1:0] RETRY_INTERVAL, // Retry time, cycles
	input wire logic [`GDFM_DRIVE_W-1:0] GATE_DRIVE_WINDOW, // Drive window, cycles
	input wire logic [`GDFM_RST_W-1:0] RESET_PULSE_WIDTH, // Enable reset pulse, cycles
	input wire logic PUMP_UV_DISABLE, // Pump UV protection off
	input wire logic GATE_FAULT_DISABLE, // Gate fault protection off
	input wire logic THERMAL_WARN_REPORT_EN, // Warning drives indicator
	input wire logic THERMAL_SHUTDOWN_RECOVERY_SEL, // 1: auto thermal recovery
	input wire gdfm_pkg::gdfm_mode_t PWM_MODE, // Input mode
	input wire logic [2:0] PHASE_IND_HB, // Phases set as independent half-bridge
	output logic [5:0] GATE_EN, // Per-FET driver enable
	output logic PUMP_EN, // Charge pump enable
	output logic ERROR_INDICATOR_N, // Fault indicator, active low
	output logic GLOBAL_ERROR_FLAG, // OR of all fault bits
	output logic SUPPLY_UNDERVOLT_FLAG, // Latched supply UV
	output logic PUMP_UNDERVOLT_FLAG, // Latched pump UV
	output logic DRAIN_SOURCE_OVERCURRENT, // Latched overcurrent
	output logic [5:0] OC_PER_FET, // Per-FET overcurrent
	output logic GATE_DRIVE_FAULT, // Latched gate fault
	output logic [5:0] GATE_FAULT_PER_FET, // Per-FET gate fault
	output logic THERMAL_WARNING_FLAG, // Thermal warning
	output logic THERMAL_SHUTDOWN_FLAG, // Latched thermal shutdown
	output logic [2:0] BRIDGE_OC_DIS // Effective bridge disables
);
	import gdfm_pkg::*;

	logic rst_s1, rst_n; // Reset synchroniser
	logic en_d, sl_d; // Pin history for pulse detection
	logic [`GDFM_RST_W-1:0] en_low_cnt; // Enable low duration
	logic en_reset, sl_reset; // Reset pulses seen
	logic clr; // Any clear event
	logic [5:0] oc_event; // Deglitched overcurrent events
	logic [5:0] gf_event; // Gate window expiries
	logic [`GDFM_RETRY_W-1:0] retry_cnt; // Retry timer
	logic retry_run; // Retry pending
	logic [5:0] gate_off; // Gate-fault isolation mask
	logic hold_all; // Global shutdown condition
	logic oc_block; // Overcurrent shutdown active
	logic therm_block; // Thermal shutdown active
	logic [7:0] eff_deg; // Effective deglitch count
	gdfm_overcurrent_mode_sel_t eff_mode; // Effective overcurrent mode

	// Reset release through two flops
	always_ff @(posedge CORE_CLK or negedge RSTN) begin
		if (!RSTN) begin
			rst_s1 <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_s1 <= 1'b1;
			rst_n <= rst_s1;
		end
	end

	// Pin variant fixes deglitch; mode is latched, or off when threshold pin selects disabled
	always_comb begin
		eff_deg = HW_VARIANT ? 8'(`GDFM_HW_DEGLITCH_CYC) : OVERCURRENT_DEGLITCH_SEL;
		if (HW_VARIANT) begin
			eff_mode = HW_OC_DISABLED ? GDFM_OCP_OFF : GDFM_OCP_LATCH;
		end else begin
			eff_mode = OVERCURRENT_MODE_SEL;
		end
	end

	// Enable and sleep reset pulse detection; short enable lows ignored, any sleep pulse counts
	always_ff @(posedge CORE_CLK or negedge rst_n) begin
		if (!rst_n) begin
			en_d <= 1'b1;
			sl_d <= 1'b1;
			en_low_cnt <= '0;
			en_reset <= 1'b0;
			sl_reset <= 1'b0;
		end else begin
			en_d <= ENABLE;
			sl_d <= SLEEP_CONTROL_N;
			if (!ENABLE) begin
				if (en_low_cnt != '1) en_low_cnt <= en_low_cnt + 1'b1;
			end else begin
				en_low_cnt <= '0;
			end
			// Pulse counts only if low long enough
			en_reset <= ENABLE && !en_d && (en_low_cnt >= RESET_PULSE_WIDTH);
			sl_reset <= SLEEP_CONTROL_N && !sl_d;
		end
	end

	assign clr = CLEAR_FAULTS_CMD || en_reset || sl_reset;

	// Bridge disables locked while monitor is off
	always_ff @(posedge CORE_CLK or negedge rst_n) begin
		if (!rst_n) begin
			BRIDGE_OC_DIS <= 3'h0;
		end else if (BRIDGE_DIS_WRITE && eff_mode != GDFM_OCP_OFF) begin
			BRIDGE_OC_DIS <= BRIDGE_OVERCURRENT_DISABLE;
		end
	end

	// Per-FET deglitch and gate window timers
	genvar g;
	generate
		for (g = 0; g < 6; g++) begin : g_fet
			logic [7:0] deg_cnt; // Time above threshold
			logic [`GDFM_DRIVE_W-1:0] drv_cnt; // Time gate has been slewing
			// Overcurrent only counted on enabled, monitored FETs
			always_ff @(posedge CORE_CLK or negedge rst_n) begin
				if (!rst_n) begin
					deg_cnt <= 8'h00;
				end else if (DS_OVER[g] && GATE_EN[g] && GATE_CMD[g] && !BRIDGE_OC_DIS[g/2]
					&& eff_mode != GDFM_OCP_OFF) begin
					if (deg_cnt != 8'hff) deg_cnt <= deg_cnt + 8'h01;
				end else begin
					deg_cnt <= 8'h00;
				end
			end
			assign oc_event[g] = deg_cnt > eff_deg;
			// Window cleared while gate matches its command or is disabled; doubles as blanking
			always_ff @(posedge CORE_CLK or negedge rst_n) begin
				if (!rst_n) begin
					drv_cnt <= '0;
				end else if (!GATE_EN[g] || GATE_CMD[g] == GATE_SENSE[g]) begin
					drv_cnt <= '0;
				end else if (drv_cnt != '1) begin
					drv_cnt <= drv_cnt + 1'b1;
				end
			end
			assign gf_event[g] = GATE_EN[g] && GATE_CMD[g] != GATE_SENSE[g]
				&& drv_cnt >= GATE_DRIVE_WINDOW;
		end
	endgenerate

	// Supply and pump undervoltage flags; set wins over clear
	always_ff @(posedge CORE_CLK or negedge rst_n) begin
		if (!rst_n) begin
			SUPPLY_UNDERVOLT_FLAG <= 1'b0;
			PUMP_UNDERVOLT_FLAG <= 1'b0;
		end else begin
			if (SUPPLY_UV) SUPPLY_UNDERVOLT_FLAG <= 1'b1;
			else if (clr) SUPPLY_UNDERVOLT_FLAG <= 1'b0;
			// Pump off by thermal shutdown must not look like pump UV
			if (PUMP_UV && PUMP_EN) PUMP_UNDERVOLT_FLAG <= 1'b1;
			else if (clr) PUMP_UNDERVOLT_FLAG <= 1'b0;
		end
	end

	// Overcurrent flags and retry timer
	always_ff @(posedge CORE_CLK or negedge rst_n) begin
		if (!rst_n) begin
			OC_PER_FET <= 6'h00;
			DRAIN_SOURCE_OVERCURRENT <= 1'b0;
			retry_cnt <= '0;
			retry_run <= 1'b0;
		end else if (|oc_event) begin
			OC_PER_FET <= OC_PER_FET | oc_event;
			DRAIN_SOURCE_OVERCURRENT <= 1'b1;
			retry_run <= eff_mode == GDFM_OCP_RETRY;
			retry_cnt <= '0;
		end else if (retry_run) begin
			// Retry expiry restarts and clears flags
			if (retry_cnt >= RETRY_INTERVAL) begin
				OC_PER_FET <= 6'h00;
				DRAIN_SOURCE_OVERCURRENT <= 1'b0;
				retry_run <= 1'b0;
			end else begin
				retry_cnt <= retry_cnt + 1'b1;
			end
		end else if (clr) begin
			OC_PER_FET <= 6'h00;
			DRAIN_SOURCE_OVERCURRENT <= 1'b0;
		end
	end

	// Gate fault flags and isolation mask
	always_ff @(posedge CORE_CLK or negedge rst_n) begin
		if (!rst_n) begin
			GATE_FAULT_PER_FET <= 6'h00;
			GATE_DRIVE_FAULT <= 1'b0;
			gate_off <= 6'h00;
		end else if (|gf_event) begin
			GATE_FAULT_PER_FET <= GATE_FAULT_PER_FET | gf_event;
			GATE_DRIVE_FAULT <= 1'b1;
			// Disable is ignored on the pin variant
			if (!GATE_FAULT_DISABLE || HW_VARIANT) begin
				for (int i = 0; i < 6; i++) begin
					if (gf_event[i]) begin
						if (PWM_MODE inside {GDFM_PWM_6X, GDFM_PWM_3X, GDFM_PWM_1X}) begin
							gate_off <= 6'h3f;
						end else if (PWM_MODE == GDFM_IND_HB || PHASE_IND_HB[i/2]) begin
							gate_off[(i/2)*2] <= 1'b1;
							gate_off[(i/2)*2+1] <= 1'b1;
						end else begin
							gate_off[i] <= 1'b1;
						end
					end
				end
			end
		end else if (clr) begin
			GATE_FAULT_PER_FET <= 6'h00;
			GATE_DRIVE_FAULT <= 1'b0;
			gate_off <= 6'h00;
		end
	end

	// Thermal warning follows comparator on register variant only; shutdown latched
	always_ff @(posedge CORE_CLK or negedge rst_n) begin
		if (!rst_n) begin
			THERMAL_WARNING_FLAG <= 1'b0;
			THERMAL_SHUTDOWN_FLAG <= 1'b0;
		end else begin
			THERMAL_WARNING_FLAG <= THERM_WARN && !HW_VARIANT;
			if (THERM_SD) THERMAL_SHUTDOWN_FLAG <= 1'b1;
			else if (clr) THERMAL_SHUTDOWN_FLAG <= 1'b0;
		end
	end

	// Shutdown conditions for gates and pump
	assign oc_block = DRAIN_SOURCE_OVERCURRENT
		&& (retry_run || eff_mode == GDFM_OCP_LATCH);
	// Latched mode waits for the flag; auto mode only the comparator
	assign therm_block = THERM_SD || (!THERMAL_SHUTDOWN_RECOVERY_SEL && THERMAL_SHUTDOWN_FLAG);
	assign hold_all = SUPPLY_UV || (PUMP_UV && PUMP_EN && (!PUMP_UV_DISABLE || HW_VARIANT))
		|| oc_block || therm_block;

	// Outputs from flops: gates, pump, global flag, indicator
	always_ff @(posedge CORE_CLK or negedge rst_n) begin
		if (!rst_n) begin
			GATE_EN <= 6'h00;
			PUMP_EN <= 1'b0;
			GLOBAL_ERROR_FLAG <= 1'b0;
			ERROR_INDICATOR_N <= 1'b1;
		end else begin
			GATE_EN <= hold_all ? 6'h00 : ~gate_off;
			PUMP_EN <= !SUPPLY_UV && !therm_block;
			GLOBAL_ERROR_FLAG <= SUPPLY_UNDERVOLT_FLAG || PUMP_UNDERVOLT_FLAG
				|| DRAIN_SOURCE_OVERCURRENT || GATE_DRIVE_FAULT || THERMAL_SHUTDOWN_FLAG
				|| THERMAL_WARNING_FLAG;
			ERROR_INDICATOR_N <= !(SUPPLY_UV || (PUMP_UV && (!PUMP_UV_DISABLE || HW_VARIANT))
				|| (DRAIN_SOURCE_OVERCURRENT && eff_mode != GDFM_OCP_OFF)
				|| (GATE_DRIVE_FAULT && |gate_off) || therm_block
				|| (THERMAL_WARNING_FLAG && THERMAL_WARN_REPORT_EN));
		end
	end

	// Checks
	property p_uv_gates;
		@(posedge CORE_CLK) disable iff (!rst_n) SUPPLY_UV |=> GATE_EN == 6'h00 && !PUMP_EN;
	endproperty
	a_uv_gates: assert property (p_uv_gates) else $error("gates on during supply UV");
	property p_uv_flag;
		@(posedge CORE_CLK) disable iff (!rst_n) SUPPLY_UV ##1 !SUPPLY_UV && !clr |=> SUPPLY_UNDERVOLT_FLAG;
	endproperty
	a_uv_flag: assert property (p_uv_flag) else $error("supply UV flag lost");
	property p_oc_deg;
		@(posedge CORE_CLK) disable iff (!rst_n) $rose(DRAIN_SOURCE_OVERCURRENT) |-> $past(|oc_event);
	endproperty
	a_oc_deg: assert property (p_oc_deg) else $error("overcurrent without event");
	property p_report;
		@(posedge CORE_CLK) disable iff (!rst_n)
		eff_mode == GDFM_OCP_REPORT && |oc_event |=> ##1 !ERROR_INDICATOR_N;
	endproperty
	a_report: assert property (p_report) else $error("report mode no indicator");
	property p_ts;
		@(posedge CORE_CLK) disable iff (!rst_n) THERM_SD |=> !PUMP_EN && !ERROR_INDICATOR_N ##0 THERMAL_SHUTDOWN_FLAG;
	endproperty
	a_ts: assert property (p_ts) else $error("thermal shutdown ignored");
	property p_pwm_all;
		@(posedge CORE_CLK) disable iff (!rst_n)
		|gf_event && PWM_MODE == GDFM_PWM_6X && !GATE_FAULT_DISABLE |=> ##1 GATE_EN == 6'h00;
	endproperty
	a_pwm_all: assert property (p_pwm_all) else $error("gate fault not global");
	property p_lock;
		@(posedge CORE_CLK) disable iff (!rst_n) eff_mode == GDFM_OCP_OFF |=> $stable(BRIDGE_OC_DIS);
	endproperty
	a_lock: assert property (p_lock) else $error("bridge disables changed");
	property p_global;
		@(posedge CORE_CLK) disable iff (!rst_n) THERMAL_SHUTDOWN_FLAG |=> GLOBAL_ERROR_FLAG;
	endproperty
	a_global: assert property (p_global) else $error("global flag missing");
	// Warning flag follows its comparator on the register variant
	property p_warn;
		@(posedge CORE_CLK) disable iff (!rst_n) THERM_WARN && !HW_VARIANT |=> THERMAL_WARNING_FLAG;
	endproperty
	a_warn: assert property (p_warn) else $error("thermal warning not flagged");
	// A pump stopped by us must never show up as pump undervoltage
	property p_pump_tsd;
		@(posedge CORE_CLK) disable iff (!rst_n) !PUMP_EN |=> !$rose(PUMP_UNDERVOLT_FLAG);
	endproperty
	a_pump_tsd: assert property (p_pump_tsd) else $error("pump flag while pump off");
	// Clear drops the supply flag once the condition has gone
	property p_clr;
		@(posedge CORE_CLK) disable iff (!rst_n)
		CLEAR_FAULTS_CMD && !SUPPLY_UV |=> !SUPPLY_UNDERVOLT_FLAG;
	endproperty
	a_clr: assert property (p_clr) else $error("supply flag survived clear");
	// Main scenarios reached
	c_report: cover property (@(posedge CORE_CLK) disable iff (!rst_n)
		eff_mode == GDFM_OCP_REPORT && DRAIN_SOURCE_OVERCURRENT);
	c_retry: cover property (@(posedge CORE_CLK) disable iff (!rst_n) retry_run ##1 !retry_run);
	c_gf: cover property (@(posedge CORE_CLK) disable iff (!rst_n) |gf_event);
	c_clr: cover property (@(posedge CORE_CLK) disable iff (!rst_n) en_reset);
endmodule : gdfm_fault_manager

/* verif/gdfm_ctrl_model.sv */
// Controller and gate-stage model facing the fault manager
`include "gdfm_defs.svh"
module gdfm_ctrl_model (
	input wire logic clk, // Core clock
	input wire logic [5:0] gate_cmd, // Commanded gates
	input wire logic [5:0] gate_en, // Driver enables from the block
	input wire logic [5:0] stuck, // Gates that never reach their level
	input wire logic pulse_req, // Ask for an enable reset pulse
	input wire logic [`GDFM_RST_W-1:0] width, // Reset pulse width, cycles
	output logic [5:0] gate_sense, // Gate level reached
	output logic enable // Enable pin
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [`GDFM_RST_W+1:0] low_left = '0; // Cycles of enable low still to go
	logic [5:0] sense_q = 6'h00; // Settled gate levels
	// Gate settles one cycle after drive; a stuck gate never rises
	always_ff @(posedge clk) begin
		sense_q <= gate_cmd & gate_en & ~stuck;
	end
	// Two spare cycles so the pulse can never fall short of the width
	always_ff @(posedge clk) begin
		if (pulse_req && low_left == '0) begin
			low_left <= {2'b00, width} + 2'd2;
		end else if (low_left != '0) begin
			low_left <= low_left - 1'b1;
		end
	end
	assign gate_sense = sense_q;
	assign enable = (low_left == '0);
endmodule : gdfm_ctrl_model

/* verif/gdfm_fault_manager_test.sv */
// Self-checking bench for the gate driver fault manager
`include "gdfm_defs.svh"
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin fail_count++; \
	$display("unexpected %s exp %h got %h", nm, ex, got); end end
module gdfm_fault_manager_test;
	timeunit 1ns;
	timeprecision 1ns;
	import gdfm_pkg::*;
	localparam logic [7:0] DEG = 8'h05; // Short deglitch keeps runs brief
	localparam logic [15:0] RETRY = 16'h001e; // Retry interval, cycles
	localparam logic [11:0] WIN = 12'h00a; // Gate drive window, cycles
	localparam logic [11:0] RSTW = 12'h008; // Enable reset pulse width
	logic clk = 0, rstn = 0, sup_uv = 0, pump_uv = 0, tw = 0, tsd = 0, sleep_n = 1, clr = 0;
	logic pump_dis = 0, gdf_dis = 0, tw_rep = 0, tsd_sel = 0, preq = 0, enable;
	logic [5:0] ds = 0, cmd = 0, stuck = 0, gate_sense, gate_en, oc_fet, gf_fet;
	logic pump_en, err_n, glob, sup_f, pump_f, oc_f, gd_f, tw_f, tsd_f;
	logic bwr = 0; // Bridge disable write strobe
	logic [2:0] bdis = 0, boc; // Bridge disables written and in effect
	gdfm_overcurrent_mode_sel_t ocm = GDFM_OCP_LATCH; // Overcurrent response
	gdfm_mode_t pwm = GDFM_PWM_6X; // Input mode
	int fail_count = 0, n_checks = 0, f;
	logic [31:0] seed = 32'hf122, r; // Fixed seed keeps runs repeatable
	gdfm_fault_manager dut (.CORE_CLK(clk), .RSTN(rstn), .HW_VARIANT(1'b0), .SUPPLY_UV(sup_uv),
		.PUMP_UV(pump_uv), .DS_OVER(ds), .GATE_CMD(cmd), .GATE_SENSE(gate_sense),
		.THERM_WARN(tw), .THERM_SD(tsd), .ENABLE(enable), .SLEEP_CONTROL_N(sleep_n),
		.CLEAR_FAULTS_CMD(clr), .OVERCURRENT_MODE_SEL(ocm), .OVERCURRENT_DEGLITCH_SEL(DEG),
		.HW_OC_DISABLED(1'b0), .BRIDGE_OVERCURRENT_DISABLE(bdis), .BRIDGE_DIS_WRITE(bwr),
		.RETRY_INTERVAL(RETRY), .GATE_DRIVE_WINDOW(WIN), .RESET_PULSE_WIDTH(RSTW),
		.PUMP_UV_DISABLE(pump_dis), .GATE_FAULT_DISABLE(gdf_dis),
		.THERMAL_WARN_REPORT_EN(tw_rep), .THERMAL_SHUTDOWN_RECOVERY_SEL(tsd_sel),
		.PWM_MODE(pwm), .PHASE_IND_HB(3'h0), .GATE_EN(gate_en), .PUMP_EN(pump_en),
		.ERROR_INDICATOR_N(err_n), .GLOBAL_ERROR_FLAG(glob), .SUPPLY_UNDERVOLT_FLAG(sup_f),
		.PUMP_UNDERVOLT_FLAG(pump_f), .DRAIN_SOURCE_OVERCURRENT(oc_f), .OC_PER_FET(oc_fet),
		.GATE_DRIVE_FAULT(gd_f), .GATE_FAULT_PER_FET(gf_fet), .THERMAL_WARNING_FLAG(tw_f),
		.THERMAL_SHUTDOWN_FLAG(tsd_f), .BRIDGE_OC_DIS(boc));
	gdfm_ctrl_model partner (.clk(clk), .gate_cmd(cmd), .gate_en(gate_en), .stuck(stuck),
		.pulse_req(preq), .width(RSTW), .gate_sense(gate_sense), .enable(enable));
	// Free-running core clock, 100 ns period
	initial begin
		forever #50 clk = ~clk;
	end
	// Xorshift source for random stimulus
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : xs
	// Surviving gates after a gate fault on one FET
	function automatic logic [5:0] exp_gates(input gdfm_mode_t md, input int fet, input logic dis);
		if (dis) return 6'h3f;
		case (md)
			GDFM_IND_HB: return ~(6'h03 << (fet / 2 * 2));
			GDFM_IND_4, GDFM_IND_5, GDFM_IND_6, GDFM_IND_FET: return ~(6'h01 << fet);
			default: return 6'h00;
		endcase
	endfunction : exp_gates
	// Let n edges pass, then sample at the falling edge where outputs are settled
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		@(negedge clk);
	endtask : tick
	task automatic clear;
		@(posedge clk) clr <= 1;
		@(posedge clk) clr <= 0;
		tick(3);
	endtask : clear
	// Healthy state: no flag, indicator released, all drivers on
	task automatic idle_chk;
		`CHK("idle", 9'h0ff, {glob, err_n, pump_en, gate_en})
	endtask : idle_chk
	task automatic conclude;
		if (fail_count == 0 && n_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : conclude
	// Watchdog sized well past the whole sequence
	initial begin
		#(100 * 20000);
		fail_count++;
		conclude;
	end
	initial begin
		repeat (6) @(posedge clk);
		rstn <= 1;
		tick(3);
		idle_chk;
		// Random command traffic must not look like a stuck gate
		for (int i = 0; i < 20; i++) begin
			r = xs();
			@(posedge clk) cmd <= r[5:0];
		end
		@(posedge clk) cmd <= 0;
		tick(2);
		idle_chk;
		@(posedge clk) sup_uv <= 1;
		tick(4);
		`CHK("uv out", 9'h100, {glob & sup_f, pump_en, err_n, gate_en})
		@(posedge clk) sup_uv <= 0;
		tick(4);
		`CHK("uv kept", 10'h3ff, {sup_f, glob, err_n, pump_en, gate_en})
		clear;
		idle_chk;
		for (int d = 0; d < 2; d++) begin
			@(posedge clk) begin pump_dis <= d[0]; pump_uv <= 1; end
			tick(4);
			`CHK("pump", {1'b1, d[0], d[0] ? 6'h3f : 6'h00}, {pump_f, err_n, gate_en})
			@(posedge clk) pump_uv <= 0;
			tick(4);
			`CHK("pump resume", 7'h7f, {pump_f, gate_en})
			@(posedge clk) preq <= 1;
			@(posedge clk) preq <= 0;
			tick(RSTW + 8);
			`CHK("pump cleared", 1'b0, pump_f)
		end
		@(posedge clk) pump_dis <= 0;
		for (int m = 0; m < 4; m++) begin
			r = xs();
			@(posedge clk) begin ocm <= gdfm_overcurrent_mode_sel_t'(m); cmd <= 6'h01; ds <= 6'h01; end
			repeat (1 + r % (DEG - 1)) @(posedge clk);
			ds <= 0;
			tick(3);
			`CHK("oc glitch", 1'b0, oc_f)
			@(posedge clk) ds <= 6'h01;
			tick(DEG + 5);
			`CHK("oc flag", {m != 3, m != 3 ? 6'h01 : 6'h00}, {oc_f, oc_fet})
			`CHK("oc gates", m < 2 ? 6'h00 : 6'h3f, gate_en)
			`CHK("oc ind", m == 3, err_n)
			@(posedge clk) begin ds <= 0; cmd <= 0; end
			tick(4);
			`CHK("oc hold", m < 2 ? 6'h00 : 6'h3f, gate_en)
			if (m == 1) tick(RETRY + 4);
			else clear;
			`CHK("oc done", 1'b0, oc_f)
			idle_chk;
		end
		// Bridge disable writes: refused while monitor off, then mask FET 0
		@(posedge clk) begin ocm <= GDFM_OCP_OFF; bdis <= 3'h5; bwr <= 1; end
		@(posedge clk) bwr <= 0;
		tick(2);
		`CHK("bdis lock", 3'h0, boc)
		@(posedge clk) begin ocm <= GDFM_OCP_LATCH; bdis <= 3'h1; bwr <= 1; end
		@(posedge clk) begin bwr <= 0; cmd <= 6'h01; ds <= 6'h01; end
		tick(DEG + 5);
		`CHK("bdis mask", 4'h1, {oc_f, boc})
		@(posedge clk) begin bdis <= 3'h0; bwr <= 1; ds <= 0; cmd <= 0; end
		@(posedge clk) bwr <= 0;
		tick(2);
		idle_chk;
		for (int e = 0; e < 2; e++) begin
			@(posedge clk) begin tw_rep <= e[0]; tw <= 1; end
			tick(3);
			`CHK("warn", {1'b1, ~e[0], 6'h3f}, {tw_f, err_n, gate_en})
			@(posedge clk) tw <= 0;
			tick(3);
			idle_chk;
		end
		for (int s = 0; s < 2; s++) begin
			@(posedge clk) begin tsd_sel <= s[0]; tsd <= 1; end
			repeat (3) @(posedge clk);
			pump_uv <= 1;
			tick(3);
			`CHK("tsd", 10'h200, {tsd_f, pump_f, pump_en, err_n, gate_en})
			@(posedge clk) begin tsd <= 0; pump_uv <= 0; end
			tick(4);
			`CHK("tsd hold", {1'b1, s[0] ? 6'h3f : 6'h00}, {tsd_f, gate_en})
			if (s == 0) begin
				@(posedge clk) sleep_n <= 0;
				@(posedge clk) sleep_n <= 1;
				tick(4);
			end else clear;
			`CHK("tsd clear", 2'b01, {tsd_f, pump_en})
			idle_chk;
		end
		for (int i = 0; i < 9; i++) begin
			r = xs();
			f = int'(r % 6);
			@(posedge clk) begin
				pwm <= gdfm_mode_t'(i[2:0]);
				gdf_dis <= (i == 8);
				cmd <= 6'h3f;
				stuck <= 6'h01 << f;
			end
			tick(WIN + 6);
			`CHK("gdf fet", 6'h01 << f, gf_fet)
			`CHK("gdf gates", exp_gates(gdfm_mode_t'(i[2:0]), f, i == 8), gate_en)
			if (i < 8) `CHK("gdf flag", 2'b10, {gd_f, err_n})
			@(posedge clk) begin stuck <= 0; cmd <= 0; end
			tick(3);
			clear;
			`CHK("gdf cleared", 7'h00, {gd_f, gf_fet})
			idle_chk;
		end
		conclude;
	end
endmodule : gdfm_fault_manager_test
